// ### hw/power_on_off_control.sv
`timescale 1ns/1ps

// Operation
// [R1] stand-alone: power up after mode pin held high longer than 2 ms
// [R2] serial control: power up on a start condition of the two-wire bus
// [R3] slider modes: shut down after mode pin held low for 10 ms
// [R4] button mode, running: shut down after mode pin high longer than 2.4 s
// [R5] power down when software writes the keep-alive bit to zero
// [R6] host sets serial-control-select before clearing the keep-alive bit
// [R7] bypass switches disabled while powered, enabled while off
// [R8] two config bits select button, slider or full slider mode
// [R9] level timers need a continuous level and restart on any change
module power_on_off_control #(
  parameter int unsigned UP_CYC = pwr_pkg::UP_HOLD_CYC,
  parameter int unsigned SLIDE_CYC = pwr_pkg::SLIDE_OFF_CYC,
  parameter int unsigned BTN_CYC = pwr_pkg::BTN_OFF_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // pins: mode pin doubles as serial clock
  input wire logic mode_scl_i,
  input wire logic sda_i,
  // register port
  input wire pwr_pkg::reg_req_t reg_req_i,
  output logic [pwr_pkg::DATA_W-1:0] rdata_o,
  // power control
  output logic chip_on_o,
  output logic bypass_en_o
);

  pwr_pkg::state_t r;
  pwr_pkg::state_t next_r;

  // --------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------
  function automatic logic hit(input pwr_pkg::reg_req_t q, input logic [pwr_pkg::ADDR_W-1:0] a);
    hit = (q.addr == a);
  endfunction : hit

  logic start_det;
  logic ka_clear;
  logic slider_mode;
  logic button_mode;
  logic pin_up;
  logic slide_down;
  logic btn_down;
  pwr_pkg::ctrl_t wr_ctrl;

  // --------------------------------------------------------------
  // event terms
  // --------------------------------------------------------------
  always_comb begin
    wr_ctrl = pwr_pkg::ctrl_t'(reg_req_i.wdata[3:0]);
    // start condition: data falls while serial clock is high
    // built from the registered stages only, so no loop through next_r
    start_det = r.sda_lvl && !r.sda_sync[1] && !r.sda_sync[2] &&
                r.mode_lvl && (r.mode_sync[1] || r.mode_sync[2]);
    // [R5] keep-alive clear, honoured only with select already set
    ka_clear = reg_req_i.wr && hit(reg_req_i, pwr_pkg::CTRL_ADDR) &&
               !wr_ctrl.power_keep_alive && r.ctrl.serial_select;
    // [R8] mode select bits
    slider_mode = r.ctrl.slide_switch_power;
    button_mode = !r.ctrl.slide_switch_power && !r.ctrl.slide_switch_monitor;
    // [R1] qualified high level
    pin_up = !r.ctrl.serial_select && r.mode_lvl &&
             (r.cnt >= pwr_pkg::cnt_t'(UP_CYC - 1));
    // [R3] slider off level
    slide_down = !r.ctrl.serial_select && slider_mode && !r.mode_lvl &&
                 (r.cnt >= pwr_pkg::cnt_t'(SLIDE_CYC - 1));
    // [R4] long press
    btn_down = !r.ctrl.serial_select && button_mode && r.mode_lvl &&
               (r.cnt >= pwr_pkg::cnt_t'(BTN_CYC - 1));
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    next_r = r;
    // three-stage synchronisers, change taken when stages 2 and 3 agree
    next_r.mode_sync = {r.mode_sync[1:0], mode_scl_i};
    next_r.sda_sync = {r.sda_sync[1:0], sda_i};
    if (r.mode_sync[1] == r.mode_sync[2]) begin
      next_r.mode_lvl = r.mode_sync[2];
    end
    if (r.sda_sync[1] == r.sda_sync[2]) begin
      next_r.sda_lvl = r.sda_sync[2];
    end

    // register writes
    if (reg_req_i.wr && hit(reg_req_i, pwr_pkg::CTRL_ADDR)) begin
      next_r.ctrl = wr_ctrl;
    end

    // power state machine
    case (r.st)
      pwr_pkg::PWR_OFF: begin
        // [R1] pin power-up
        if (pin_up) begin
          next_r.st = pwr_pkg::PWR_ON;
        // [R2] start condition power-up
        end else if (r.ctrl.serial_select && start_det) begin
          next_r.st = pwr_pkg::PWR_ON;
        end
      end
      pwr_pkg::PWR_ON: begin
        // [R3] [R4] [R5] shutdown sources
        if (ka_clear || slide_down || btn_down) begin
          next_r.st = pwr_pkg::PWR_OFF;
        end
      end
      default: begin
        next_r.st = pwr_pkg::PWR_OFF;
      end
    endcase

    // keep-alive is set by hardware at power-up; the set wins over a write
    if (r.st == pwr_pkg::PWR_OFF && next_r.st == pwr_pkg::PWR_ON) begin
      next_r.ctrl.power_keep_alive = 1'b1;
    end

    // [R9] timer restarts on any level or state change
    if (next_r.mode_lvl != r.mode_lvl || next_r.st != r.st) begin
      next_r.cnt = pwr_pkg::CNT_ZERO;
    end else if (r.cnt != pwr_pkg::CNT_MAX) begin
      next_r.cnt = r.cnt + pwr_pkg::CNT_ONE;
    end

    // [R7] bypass follows the power state
    next_r.chip_on = (next_r.st == pwr_pkg::PWR_ON);
    next_r.bypass_en = (next_r.st != pwr_pkg::PWR_ON);

    // read data stand for one cycle only
    next_r.rdata = '0;
    if (reg_req_i.rd) begin
      if (hit(reg_req_i, pwr_pkg::CTRL_ADDR)) begin
        next_r.rdata = {pwr_pkg::CTRL_PAD, r.ctrl};
      end else if (hit(reg_req_i, pwr_pkg::STATUS_ADDR)) begin
        next_r.rdata = {pwr_pkg::STATUS_PAD, r.mode_lvl, r.chip_on};
      end
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r.st <= pwr_pkg::PWR_OFF;
      r.mode_sync <= 3'h0;
      r.sda_sync <= 3'h7;
      r.mode_lvl <= 1'b0;
      r.sda_lvl <= 1'b1;
      r.cnt <= pwr_pkg::CNT_ZERO;
      r.ctrl <= pwr_pkg::CTRL_RESET;
      r.rdata <= '0;
      r.chip_on <= 1'b0;
      r.bypass_en <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o = r.rdata;
  assign chip_on_o = r.chip_on;
  assign bypass_en_o = r.bypass_en;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // [R1] pin power-up only after the full high time
  AST_PIN_UP_QUALIFIED: assert property ( // [R1]
    ($rose(chip_on_o) && !$past(r.ctrl.serial_select)) |->
      ($past(r.mode_lvl) && $past(r.cnt) >= pwr_pkg::cnt_t'(UP_CYC - 1)))
    else $error("power-up from pin without qualified high level");

  // [R2] start condition turns the chip on
  AST_START_UP: assert property ( // [R2]
    (r.st == pwr_pkg::PWR_OFF && r.ctrl.serial_select && start_det) |=>
      (chip_on_o && r.ctrl.power_keep_alive))
    else $error("start condition did not power up");

  // [R3] slider low time shuts down
  AST_SLIDE_DOWN: assert property ( // [R3]
    (chip_on_o && slide_down) |=> (!chip_on_o && bypass_en_o))
    else $error("slider low level did not shut down");

  // [R4] button high level shorter than the long press time never shuts down
  AST_BTN_DOWN: assert property ( // [R4]
    (chip_on_o && button_mode && !r.ctrl.serial_select && r.mode_lvl &&
     r.cnt < pwr_pkg::cnt_t'(BTN_CYC - 1) && !ka_clear) |=> chip_on_o)
    else $error("button shutdown before long press time");

  // [R5] keep-alive clear powers down
  AST_KA_DOWN: assert property ( // [R5]
    (chip_on_o && ka_clear) |=> !chip_on_o ##1 !chip_on_o)
    else $error("keep-alive clear did not power down");

  // [R7] bypass is the complement of power
  AST_BYPASS: assert property ( // [R7]
    bypass_en_o != chip_on_o)
    else $error("bypass enabled while powered");

  // [R8] monitor bit alone gives no pin shutdown
  AST_MON_ONLY: assert property ( // [R8]
    (chip_on_o && !r.ctrl.slide_switch_power && r.ctrl.slide_switch_monitor &&
     !ka_clear) |=> chip_on_o)
    else $error("pin shutdown in unused mode");

  // [R9] level change restarts the timer
  AST_TIMER_RESTART: assert property ( // [R9]
    (r.mode_lvl != $past(r.mode_lvl)) |-> (r.cnt == pwr_pkg::CNT_ZERO))
    else $error("timer not restarted on level change");

  COV_PIN_UP: cover property ($rose(chip_on_o) && !r.ctrl.serial_select);
  COV_SERIAL_UP: cover property ($rose(chip_on_o) && r.ctrl.serial_select);
  COV_KA_DOWN: cover property (chip_on_o && ka_clear ##1 !chip_on_o);

endmodule : power_on_off_control

// ### inc/pwr_pkg.sv
package pwr_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // control register, bits 3..0 of the word
  typedef struct packed {
    logic slide_switch_monitor; // bit 3
    logic slide_switch_power;   // bit 2
    logic serial_select;        // bit 1
    logic power_keep_alive;     // bit 0
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 4'h0;
  localparam logic [27:0] CTRL_PAD = 28'h0000000;

  // status register, bits 1..0 of the word
  typedef struct packed {
    logic mode_level; // bit 1
    logic powered;    // bit 0
  } status_t;

  localparam logic [29:0] STATUS_PAD = 30'h00000000;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned UP_HOLD_US = 2_000;      // more than 2 ms high
  localparam int unsigned SLIDE_OFF_US = 10_000;   // 10 ms low
  localparam int unsigned BTN_OFF_US = 2_400_000;  // more than 2.4 s high
  // least times convert exactly; strictly longer ones get one more cycle
  localparam int unsigned UP_HOLD_CYC = (UP_HOLD_US * (CLK_HZ / 1_000_000)) + 1;
  localparam int unsigned SLIDE_OFF_CYC = SLIDE_OFF_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BTN_OFF_CYC = (BTN_OFF_US * (CLK_HZ / 1_000_000)) + 1;

  localparam int CNT_W = 25;
  typedef logic [CNT_W-1:0] cnt_t;
  localparam cnt_t CNT_ZERO = 25'h0000000;
  localparam cnt_t CNT_ONE = 25'h0000001;
  localparam cnt_t CNT_MAX = 25'h1FFFFFF;

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  typedef enum logic {
    PWR_OFF,
    PWR_ON
  } pwr_state_t;

  typedef struct packed {
    pwr_state_t st;
    logic [2:0] mode_sync;
    logic [2:0] sda_sync;
    logic mode_lvl;
    logic sda_lvl;
    cnt_t cnt;
    ctrl_t ctrl;
    logic [DATA_W-1:0] rdata;
    logic chip_on;
    logic bypass_en;
  } state_t;

endpackage : pwr_pkg

// ### tb/pin_partner.sv
`timescale 1ns/1ps

// ----------------------------------------
// push button, slide switch or bus host
// ----------------------------------------
module pin_partner (
  // clock
  input wire logic clk_i,
  // pins
  output logic mode_o,
  output logic sda_o
);
  // released pin idles low, data line pulled up
  initial begin
    mode_o = 1'b0;
    sda_o = 1'b1;
  end

  // drive a level, then keep it for n cycles
  task automatic hold(input logic v, input int n);
    mode_o <= v;
    repeat (n) @(posedge clk_i);
  endtask : hold

  // data falls while clock high, clock falls before data rises
  task automatic start();
    hold(1'b1, 5);
    sda_o <= 1'b0;
    hold(1'b1, 5);
    hold(1'b0, 2);
    sda_o <= 1'b1;
    hold(1'b0, 2);
  endtask : start
endmodule : pin_partner

// ### tb/testbench.sv
`timescale 1ns/1ps

// ----------------------------------------
// power on/off bench
// ----------------------------------------
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  pwr_pkg::reg_req_t reg_req = '0;
  logic [31:0] rdata;
  logic chip_on;
  logic bypass_en;
  logic mode_scl;
  logic sda;
  int failures = 0;
  int tests_run = 0;

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  pin_partner pp (.clk_i(core_clk), .mode_o(mode_scl), .sda_o(sda));

  power_on_off_control #(.UP_CYC(20), .SLIDE_CYC(50), .BTN_CYC(100)) dut (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .mode_scl_i(mode_scl), .sda_i(sda),
    .reg_req_i(reg_req), .rdata_o(rdata), .chip_on_o(chip_on), .bypass_en_o(bypass_en));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
    @(posedge core_clk);
  endtask : rd

  // power and bypass always opposite
  task automatic pw(input logic exp, input string what);
    #1;
    chk(what, {31'h0, exp}, {31'h0, chip_on});
    chk("bypass", {31'h0, ~exp}, {31'h0, bypass_en});
  endtask : pw

  // wait for a power change, count cycles until it lands
  task automatic wait_pw(input logic exp, input int lo, input int hi, input string what);
    int n;
    n = 0;
    while (chip_on !== exp && n < hi + 5) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(what, 32'h1, {31'h0, (n >= lo && n <= hi)});
    pw(exp, what);
  endtask : wait_pw

  task automatic t_reset();
    pw(1'b0, "reset power");
    rd(pwr_pkg::CTRL_ADDR, 32'h0, "ctrl reset");
    wr(pwr_pkg::STATUS_ADDR, 32'hFFFFFFFF);
    wr(8'h08, 32'hFFFFFFFF);
    rd(pwr_pkg::STATUS_ADDR, 32'h0, "status ro");
    rd(8'h08, 32'h0, "unmapped");
    $display("test reset done");
  endtask : t_reset

  task automatic t_pin_up();
    pp.hold(1'b1, 15);
    pp.hold(1'b0, 10);
    pw(1'b0, "short high");
    pp.hold(1'b1, 15);
    pp.hold(1'b0, 2);
    pp.hold(1'b1, 15);
    pw(1'b0, "broken high");
    pp.hold(1'b0, 10);
    pp.hold(1'b1, 0);
    wait_pw(1'b1, 20, 27, "pin up");
    rd(pwr_pkg::STATUS_ADDR, 32'h3, "status on");
    pp.hold(1'b0, 10);
    pp.hold(1'b1, 40);
    pw(1'b1, "short press");
    pp.hold(1'b0, 10);
    pp.hold(1'b1, 0);
    wait_pw(1'b0, 100, 107, "long press");
    pp.hold(1'b0, 30);
    pw(1'b0, "stays off");
    $display("test pin done");
  endtask : t_pin_up

  task automatic t_slider();
    logic [3:0] m;
    for (int i = 0; i < 2; i++) begin
      m = i ? 4'hC : 4'h4;
      wr(pwr_pkg::CTRL_ADDR, {28'h0, m});
      pp.hold(1'b1, 0);
      wait_pw(1'b1, 20, 27, "slide up");
      rd(pwr_pkg::CTRL_ADDR, {28'h0, m | 4'h1}, "keep set");
      pp.hold(1'b0, 30);
      pp.hold(1'b1, 5);
      pw(1'b1, "short low");
      pp.hold(1'b0, 0);
      wait_pw(1'b0, 50, 57, "slide off");
    end
    wr(pwr_pkg::CTRL_ADDR, 32'h8);
    pp.hold(1'b1, 0);
    wait_pw(1'b1, 20, 27, "mon up");
    pp.hold(1'b0, 80);
    pw(1'b1, "mon alone");
    wr(pwr_pkg::CTRL_ADDR, 32'hA);
    pw(1'b1, "same write");
    wr(pwr_pkg::CTRL_ADDR, 32'h8);
    pw(1'b0, "keep clr");
    $display("test slider done");
  endtask : t_slider

  task automatic t_serial();
    wr(pwr_pkg::CTRL_ADDR, 32'h2);
    pp.start();
    pw(1'b1, "start up");
    rd(pwr_pkg::CTRL_ADDR, 32'h3, "keep forced");
    wr(pwr_pkg::CTRL_ADDR, 32'h2);
    pw(1'b0, "serial off");
    $display("test serial done");
  endtask : t_serial

  task automatic test_done();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // watchdog
  initial begin
    repeat (3000) @(posedge core_clk);
    failures++;
    $display("Error watchdog expected end seen timeout");
    test_done();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_pin_up();
    t_slider();
    t_serial();
    test_done();
  end
endmodule : testbench
